//--- logic/sixpw_top.sv
// Six-channel pulse width generator with per-channel prescaler, counter and settings.
`timescale 1ns/1ns
// How it works
// - Six outputs, each with its own counter and settings.
// - Every prescaler divides the one master clock.
// - Prescaler ratio is a power of two from 2 to 128, three-bit code.
// - Up mode counts zero up to one below the limit, wraps to zero, repeats.
// - Up mode output frequency is master clock over prescaler ratio times limit; up/down mode is half that.
// - Output changes level when the counter reaches the threshold.
// - Polarity picks the level below threshold; opposite level above it.
// - Up/down mode counts up to the limit then back down to zero.
// - Per channel: limit, threshold, prescaler, polarity, mode, enable, load.
// - Each channel's settings arrive as its own slice of ports shared by all channels.
module sixpw_top
   import sixpw_pkg::*;
#(
   parameter int CHANNELS = CH_COUNT
)
(
   input  wire logic                          sys_clk,
   input  wire logic                          reset,
   input  wire logic [7:0]                    common_ctrl,
   input  wire logic [CHANNELS-1:0][15:0]     period_limit,
   input  wire logic [CHANNELS-1:0][15:0]     threshold,
   input  wire logic [CHANNELS-1:0][2:0]      presc_code,
   input  wire logic [CHANNELS-1:0]           polarity,
   input  wire logic [CHANNELS-1:0]           updown_mode,
   input  wire logic [CHANNELS-1:0]           enable,
   input  wire logic [CHANNELS-1:0]           load_enable,
   output logic      [CHANNELS-1:0]           pwm_out,
   output logic      [CHANNELS-1:0]           load_pending
);

   typedef struct packed {
      sixpw_ch_type [CHANNELS-1:0] ch;
   } sixpw_state_type;

   sixpw_state_type       st_r;
   sixpw_state_type       st_nxt;
   logic [CHANNELS-1:0]   tick_w;
   logic                  unlocked;

   // Copies one channel's limit, threshold, prescaler and mode from the input ports into its working copy.
   function automatic sixpw_ch_type sixpw_apply(input sixpw_ch_type c,
                                                input logic [15:0] top,
                                                input logic [15:0] thr,
                                                input logic [2:0]  psc,
                                                input logic        ud);
      sixpw_ch_type r;
      r      = c;
      r.top  = top;
      r.thr  = thr;
      r.psc  = psc;
      r.mode = ud ? SIXPW_MODE_UPDOWN : SIXPW_MODE_UP;
      r.pend = 1'b0;
      return r;
   endfunction

   assign unlocked = common_ctrl[UNLOCK_BIT_A] && common_ctrl[UNLOCK_BIT_B];

   // =====================================================================
   // Prescalers
   // =====================================================================
   sixpw_tick_if tk_if[CHANNELS] ();

   for (genvar g = 0; g < CHANNELS; g++) begin : g_psc
      assign tk_if[g].code = st_r.ch[g].psc;
      assign tk_if[g].run  = enable[g];
      assign tick_w[g]     = tk_if[g].tick;
      sixpw_prescaler u_psc (
         .sys_clk (sys_clk),
         .reset   (reset),
         .bus     (tk_if[g])
      );
   end

   // =====================================================================
   // Channel counters and outputs
   // =====================================================================
   always_comb begin
      sixpw_ch_type c;
      logic [16:0]  inc;
      logic [16:0]  lim;
      logic         wrap;
      c      = '0;
      inc    = 17'h0_0000;
      lim    = 17'h0_0000;
      wrap   = 1'b0;
      st_nxt = st_r;
      for (int i = 0; i < CHANNELS; i++) begin
         c    = st_r.ch[i];
         inc  = {1'b0, c.cnt} + 17'h0_0001;
         lim  = {1'b0, c.top};
         wrap = 1'b0;
         if (load_enable[i] && unlocked) begin
            c.pend = 1'b1;
         end
         if (!enable[i]) begin
            c.cnt = CNT_RST;
            c.up  = 1'b1;
            if (c.pend) begin
               c = sixpw_apply(c, period_limit[i], threshold[i], presc_code[i],
                               updown_mode[i]);
            end
         end else if (tick_w[i]) begin
            if (c.mode == SIXPW_MODE_UP) begin
               if (inc >= lim) begin
                  c.cnt = CNT_RST;
                  wrap  = 1'b1;
               end else begin
                  c.cnt = inc[15:0];
               end
            end else if (c.up) begin
               if (inc >= lim) begin
                  c.cnt = c.top;
                  c.up  = 1'b0;
               end else begin
                  c.cnt = inc[15:0];
               end
            end else begin
               if (c.cnt <= 16'h0001) begin
                  c.cnt = CNT_RST;
                  c.up  = 1'b1;
                  wrap  = 1'b1;
               end else begin
                  c.cnt = c.cnt - 16'h0001;
               end
            end
            // Only a registered load applies here; a load on the wrap edge waits a period.
            if (wrap && st_r.ch[i].pend) begin
               c      = sixpw_apply(c, period_limit[i], threshold[i], presc_code[i],
                                    updown_mode[i]);
               c.pend = load_enable[i] && unlocked;
            end
         end
         if (!enable[i]) begin
            c.out = ~polarity[i];
         end else if (c.cnt < c.thr) begin
            c.out = polarity[i];
         end else begin
            c.out = ~polarity[i];
         end
         st_nxt.ch[i] = c;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < CHANNELS; i++) begin
            st_r.ch[i] <= '{cnt: CNT_RST, up: 1'b1, out: 1'b0, pend: 1'b0,
                            top: TOP_RST, thr: THR_RST, psc: PSC_RST,
                            mode: SIXPW_MODE_UP};
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         pwm_out[i]      = st_r.ch[i].out;
         load_pending[i] = st_r.ch[i].pend;
      end
   end

   // =====================================================================
   // Checks
   // =====================================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
      // The edge that releases reset still loads the reset level, so it is left out.
      a_disabled_hold: assert property (!enable[g] && !reset |=> st_r.ch[g].cnt == CNT_RST
                                        && pwm_out[g] == ~$past(polarity[g]))
         else $error("Disabled channel did not hold counter and idle level.");
      a_out_below: assert property ($past(enable[g]) && st_r.ch[g].cnt < st_r.ch[g].thr
                                    |-> pwm_out[g] == $past(polarity[g]))
         else $error("Output below threshold does not follow polarity.");
      a_out_above: assert property ($past(enable[g]) && st_r.ch[g].cnt >= st_r.ch[g].thr
                                    |-> pwm_out[g] != $past(polarity[g]))
         else $error("Output at or above threshold did not change level.");
      a_up_wrap: assert property (enable[g] && tick_w[g] && st_r.ch[g].mode == SIXPW_MODE_UP
                                  && ({1'b0, st_r.ch[g].cnt} + 17'h0_0001
                                      >= {1'b0, st_r.ch[g].top})
                                  |=> st_r.ch[g].cnt == CNT_RST)
         else $error("Up mode counter did not wrap at the limit.");
      a_up_step: assert property (enable[g] && tick_w[g] && st_r.ch[g].mode == SIXPW_MODE_UP
                                  && ({1'b0, st_r.ch[g].cnt} + 17'h0_0001
                                      < {1'b0, st_r.ch[g].top})
                                  |=> st_r.ch[g].cnt == $past(st_r.ch[g].cnt) + 16'h0001)
         else $error("Up mode counter did not step by one.");
      a_updown_turn: assert property (enable[g] && tick_w[g] && st_r.ch[g].up
                                      && st_r.ch[g].mode == SIXPW_MODE_UPDOWN
                                      && st_r.ch[g].cnt + 16'h0001 == st_r.ch[g].top
                                      |=> !st_r.ch[g].up ##1 enable[g] && tick_w[g]
                                      |=> st_r.ch[g].cnt < st_r.ch[g].top)
         else $error("Up/down counter did not turn at the limit.");
      a_tick_hold: assert property (enable[g] && !tick_w[g] |=> $stable(st_r.ch[g].cnt))
         else $error("Counter moved without a prescaler tick.");
      a_cfg_hold: assert property (enable[g] && !st_r.ch[g].pend
                                   |=> $stable(st_r.ch[g].top) && $stable(st_r.ch[g].thr))
         else $error("Settings changed without a pending load.");
      a_load_lock: assert property (!unlocked && !st_r.ch[g].pend |=> !st_r.ch[g].pend)
         else $error("Load accepted while programming was locked.");

      c_up_wrap: cover property (enable[g] && st_r.ch[g].mode == SIXPW_MODE_UP
                                 && $past(st_r.ch[g].cnt) != CNT_RST
                                 && st_r.ch[g].cnt == CNT_RST);
      c_updown_turn: cover property (st_r.ch[g].mode == SIXPW_MODE_UPDOWN
                                     && $fell(st_r.ch[g].up));
      c_load_apply: cover property (enable[g] && $fell(st_r.ch[g].pend));
      c_disable: cover property ($fell(enable[g]));
   end

endmodule

//--- logic/sixpw_pkg.sv
// Constants, channel state type and a prescaler helper function for the six-channel pulse generator.
package sixpw_pkg;

   // =====================================================================
   // Sizes and clocking
   // =====================================================================
   localparam int          CH_COUNT      = 6;
   localparam int          CNT_W         = 16;
   localparam int          PSC_W         = 3;
   localparam int          MASTER_CLK_HZ = 16_000_000;
   localparam int          PSC_CNT_W     = 7;

   // =====================================================================
   // Common control unlock bits and reset values
   // =====================================================================
   localparam int          UNLOCK_BIT_A  = 0;
   localparam int          UNLOCK_BIT_B  = 4;
   localparam logic [15:0] CNT_RST       = 16'h0000;
   localparam logic [15:0] TOP_RST       = 16'h0000;
   localparam logic [15:0] THR_RST       = 16'h0000;
   localparam logic [2:0]  PSC_RST       = 3'h0;
   localparam logic [6:0]  PSC_CNT_RST   = 7'h00;
   localparam logic [6:0]  PSC_LAST_MAX  = 7'h7f;
   localparam logic [2:0]  PSC_CODE_MAX  = 3'h6;

   // =====================================================================
   // Counting modes
   // =====================================================================
   typedef enum logic [1:0] {
      SIXPW_MODE_UP     = 2'b01,
      SIXPW_MODE_UPDOWN = 2'b10
   } sixpw_mode_type;

   typedef struct packed {
      logic [15:0]    cnt;
      logic           up;
      logic           out;
      logic           pend;
      logic [15:0]    top;
      logic [15:0]    thr;
      logic [2:0]     psc;
      sixpw_mode_type mode;
   } sixpw_ch_type;

   // Last prescaler count for ratio 2^(code+1); codes above 6 stay at 128.
   function automatic logic [6:0] sixpw_psc_last(input logic [2:0] code);
      logic [7:0] ratio;
      ratio = 8'h02 << code;
      if (code >= PSC_CODE_MAX) begin
         return PSC_LAST_MAX;
      end
      return ratio[6:0] - 7'h01;
   endfunction

endpackage

//--- logic/sixpw_tick_if.sv
// Prescaler tick interface between the channel logic and one prescaler.
`timescale 1ns/1ns
interface sixpw_tick_if;
   logic [2:0] code;
   logic       run;
   logic       tick;

   modport prescaler (input code, input run, output tick);
   modport channel   (output code, output run, input tick);
endinterface

//--- logic/sixpw_prescaler.sv
// Power-of-two prescaler that makes one tick per ratio of master clock cycles.
`timescale 1ns/1ns
module sixpw_prescaler
   import sixpw_pkg::*;
(
   input wire logic         sys_clk,
   input wire logic         reset,
   sixpw_tick_if.prescaler  bus
);

   typedef struct packed {
      logic [6:0] cnt;
   } sixpw_psc_state_type;

   sixpw_psc_state_type st_r;
   sixpw_psc_state_type st_nxt;
   logic [6:0]          last;

   // =====================================================================
   // Divider
   // =====================================================================
   always_comb begin
      st_nxt = st_r;
      last   = sixpw_psc_last(bus.code);
      if (!bus.run) begin
         st_nxt.cnt = PSC_CNT_RST;
      end else if (st_r.cnt >= last) begin
         st_nxt.cnt = PSC_CNT_RST;
      end else begin
         st_nxt.cnt = st_r.cnt + 7'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_r <= '{cnt: PSC_CNT_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.tick = bus.run && (st_r.cnt >= last);

   // =====================================================================
   // Checks
   // =====================================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_tick_gap: assert property (bus.tick && $stable(bus.code) |=> !bus.tick)
      else $error("Prescaler ticked on two cycles in a row.");
   a_tick_idle: assert property (!bus.run |-> !bus.tick)
      else $error("Prescaler ticked while stopped.");

endmodule

//--- sim/sixpw_load_model.sv
// Passive load model that counts high cycles and rising edges on each pulse output.
`timescale 1ns/1ns
module sixpw_load_model
   import sixpw_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                meas,
   input  wire logic [CH_COUNT-1:0] pwm_out,
   output logic      [31:0]         high_cnt [CH_COUNT],
   output logic      [31:0]         rise_cnt [CH_COUNT]
);
   logic [CH_COUNT-1:0] prev_r;

   // Counts are cleared while meas is low, so a window is exactly the cycles meas is high.
   always_ff @(posedge sys_clk) begin
      prev_r <= pwm_out;
      for (int i = 0; i < CH_COUNT; i++) begin
         if (!meas) begin
            high_cnt[i] <= 32'h0000_0000;
            rise_cnt[i] <= 32'h0000_0000;
         end else begin
            high_cnt[i] <= high_cnt[i] + {31'h0000_0000, pwm_out[i]};
            rise_cnt[i] <= rise_cnt[i] + {31'h0000_0000, pwm_out[i] & ~prev_r[i]};
         end
      end
   end
endmodule

//--- sim/tb.sv
// Self-checking testbench for the six-channel pulse width generator.
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("[FAIL] t=%0t %s got %0h exp %0h", $time, msg, got, exp); \
   end \
end
module tb;
   import sixpw_pkg::*;
   logic                          sys_clk = 1'b0;
   logic                          reset = 1'b1;
   logic [7:0]                    common_ctrl = 8'h00;
   logic [CH_COUNT-1:0][15:0]     period_limit = '0;
   logic [CH_COUNT-1:0][15:0]     threshold = '0;
   logic [CH_COUNT-1:0][2:0]      presc_code = '0;
   logic [CH_COUNT-1:0]           polarity = '0;
   logic [CH_COUNT-1:0]           updown_mode = '0;
   logic [CH_COUNT-1:0]           enable = '0;
   logic [CH_COUNT-1:0]           load_enable = '0;
   logic [CH_COUNT-1:0]           pwm_out;
   logic [CH_COUNT-1:0]           load_pending;
   logic                          meas = 1'b0;
   logic [31:0]                   high_cnt [CH_COUNT];
   logic [31:0]                   rise_cnt [CH_COUNT];
   int                            n_fail = 0;
   int                            compares = 0;
   int                            seed_val;

   always #25 sys_clk = ~sys_clk;

   sixpw_top #(.CHANNELS(CH_COUNT)) uut (
      .sys_clk(sys_clk), .reset(reset), .common_ctrl(common_ctrl),
      .period_limit(period_limit), .threshold(threshold), .presc_code(presc_code),
      .polarity(polarity), .updown_mode(updown_mode), .enable(enable),
      .load_enable(load_enable), .pwm_out(pwm_out), .load_pending(load_pending)
   );

   sixpw_load_model loads (
      .sys_clk(sys_clk), .meas(meas), .pwm_out(pwm_out),
      .high_cnt(high_cnt), .rise_cnt(rise_cnt)
   );

   function automatic int ratio_of(input logic [2:0] code);
      return (code >= 3'h6) ? 128 : (2 << code);
   endfunction

   function automatic int ticks_of(input int top, input logic ud);
      return ud ? 2 * top : top;
   endfunction

   // Up/down passes the values below the threshold twice, except zero.
   function automatic int high_of(input int top, input int thr, input logic [2:0] code,
                                  input logic pol, input logic ud);
      int below;
      below = ud ? 2 * thr - 1 : thr;
      return ratio_of(code) * (pol ? below : ticks_of(top, ud) - below);
   endfunction

   task automatic give_verdict();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Loads one random setting set on channel i, then measures two full output periods.
   task automatic run_cfg(input int i, input logic live);
      int top, thr, per, n;
      logic [2:0] code;
      logic pol, ud;
      top = 2 + $urandom % 7;
      thr = 1 + $urandom % (top - 1);
      code = 3'($urandom);
      pol = 1'($urandom);
      ud = 1'($urandom);
      per = ratio_of(code) * ticks_of(top, ud);
      @(posedge sys_clk);
      period_limit[i] <= 16'(top);
      threshold[i] <= 16'(thr);
      presc_code[i] <= code;
      polarity[i] <= pol;
      updown_mode[i] <= ud;
      load_enable[i] <= 1'b1;
      @(posedge sys_clk);
      load_enable[i] <= 1'b0;
      #1;
      `CHK(load_pending[i], live, "pending after load")
      n = 0;
      while (load_pending[i] === 1'b1 && n < 4000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      `CHK(load_pending[i], 1'b0, "pending never cleared")
      @(posedge sys_clk);
      enable[i] <= 1'b1;
      repeat (per) @(posedge sys_clk);
      meas <= 1'b1;
      repeat (2 * per) @(posedge sys_clk);
      meas <= 1'b0;
      #1;
      `CHK(high_cnt[i], 32'(2 * high_of(top, thr, code, pol, ud)), "high time")
      `CHK(rise_cnt[i], 32'h0000_0002, "pulse count per window")
      $display("test cfg ch %0d live %0d done", i, live);
   endtask

   initial begin
      seed_val = $urandom(7835);
      repeat (5) @(posedge sys_clk);
      #1;
      `CHK(pwm_out, 6'h00, "output in reset")
      `CHK(load_pending, 6'h00, "pending in reset")
      @(posedge sys_clk);
      reset <= 1'b0;
      polarity <= 6'($urandom);
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK(pwm_out, ~polarity, "disabled level")
      $display("test reset and idle done");
      // Loads while locked must leave every enabled channel untouched.
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk);
         enable <= 6'h3f;
         common_ctrl <= (k == 0) ? 8'h01 : 8'h10;
         load_enable <= 6'h3f;
         @(posedge sys_clk);
         load_enable <= 6'h00;
         #1;
         `CHK(load_pending, 6'h00, "locked load taken")
      end
      @(posedge sys_clk);
      enable <= 6'h00;
      common_ctrl <= 8'h11;
      $display("test locked load done");
      for (int i = 0; i < CH_COUNT; i++) begin
         run_cfg(i, 1'b0);
         run_cfg(i, 1'b1);
         @(posedge sys_clk);
         enable[i] <= 1'b0;
         repeat (2) @(posedge sys_clk);
         #1;
         `CHK(pwm_out[i], ~polarity[i], "disabled channel level")
      end
      give_verdict();
   end

   initial begin
      #(5_000_000);
      n_fail++;
      $display("[FAIL] t=%0t watchdog expired", $time);
      give_verdict();
   end
endmodule
